// >>> pkg/smw_pkg.sv
package smw_pkg;

	localparam int N_CHAN  = 10;
	localparam int N_TMR   = 4;
	localparam int N_DIG   = 4;
	localparam int CHAN_W  = 4;
	localparam int ADC_W   = 10;
	localparam int RES_W   = 12;
	localparam int RES_HI_W = 8;
	localparam int RES_LO_W = 4;
	localparam int TCODE_W = 7;
	localparam int TCNT_W  = 19;
	localparam int FCNT_W  = 10;
	localparam int DIV_W   = 5;
	localparam int CAL_W   = 17;

	// System clock and master clock rates
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int MCLK_FREQ_KHZ  = 8000;
	localparam int MCLK_PERIOD_PS = 1000000000 / MCLK_FREQ_KHZ;
	localparam int OSC_DIV        = MCLK_PERIOD_PS / CLK_PERIOD_PS;
	localparam int OSC_HALF       = OSC_DIV / 2;
	localparam int PRESCALE       = 32;
	localparam int LCLK_FREQ_KHZ  = MCLK_FREQ_KHZ / PRESCALE;

	// Glitch filter delays, counted in master clock ticks
	localparam int FILT_ON_US     = 64;
	localparam int FILT_OFF_US    = 16;
	localparam int FILT_ON_TICKS  = FILT_ON_US * MCLK_FREQ_KHZ / 1000;
	localparam int FILT_OFF_TICKS = FILT_OFF_US * MCLK_FREQ_KHZ / 1000;

	// Comparator calibration and filter initialisation after reset
	localparam int CAL_TIME_US = 500;
	localparam int CAL_CYCLES  = CAL_TIME_US * 1000000 / CLK_PERIOD_PS;

	// Timer range, counted in logic clock ticks
	localparam int TMR_MIN_US    = 32;
	localparam int TMR_MAX_MS    = 1960;
	localparam int TMR_MIN_TICKS = TMR_MIN_US * LCLK_FREQ_KHZ / 1000;
	localparam int TMR_MAX_TICKS = TMR_MAX_MS * LCLK_FREQ_KHZ;

	typedef logic [N_CHAN-1:0] smw_chan_t;
	typedef logic [N_TMR-1:0][TCODE_W-1:0] smw_tcode_t;
	typedef enum logic [1:0] {ADC_IDLE, ADC_WAIT} smw_adc_st_t;

	// Code = {row[2:0], step[3:0]}: (step + 1) times the row base
	function automatic logic [TCNT_W-1:0] smw_tmr_ticks(input logic [TCODE_W-1:0] code);
		logic [TCNT_W-1:0] base;
		base = '0;
		case (code[6:4])
			3'h0: base = TCNT_W'(TMR_MIN_TICKS);
			3'h1: base = TCNT_W'(32);
			3'h2: base = TCNT_W'(128);
			3'h3: base = TCNT_W'(512);
			3'h4: base = TCNT_W'(2048);
			3'h5: base = TCNT_W'(8192);
			3'h6: base = TCNT_W'(16384);
			default: base = TCNT_W'(TMR_MAX_TICKS / 16);
		endcase
		return TCNT_W'(base * ({1'h0, code[3:0]} + 5'h01));
	endfunction

endpackage

// >>> pkg/smw_tick_if.sv
`timescale 1ns/10ps
interface smw_tick_if;
	logic mtick;
	logic ltick;
	logic init;
	modport src (output mtick, output ltick, output init);
	modport snk (input mtick, input ltick, input init);
endinterface

// >>> hdl/smw_glitch_filter.sv
`timescale 1ns/10ps
module smw_glitch_filter (
	input  wire logic clk,
	input  wire logic rstn,
	smw_tick_if.snk   tk,
	input  wire logic raw,
	input  wire logic en,
	output logic      q
);
	import smw_pkg::*;

	typedef struct packed {
		logic              q;
		logic [FCNT_W-1:0] cnt;
	} smw_filt_t;

	smw_filt_t filt_reg;
	smw_filt_t filt_next;
	logic [FCNT_W-1:0] limit;

	always_comb begin
		filt_next = filt_reg;
		limit = en ? FCNT_W'(FILT_ON_TICKS - 1) : FCNT_W'(FILT_OFF_TICKS - 1);
		if (tk.init) begin
			// Filter follows its input until calibration ends
			filt_next.q = raw;
			filt_next.cnt = '0;
		end else if (tk.mtick) begin
			if (raw == filt_reg.q) begin
				filt_next.cnt = '0;
			end else if (filt_reg.cnt == limit) begin
				filt_next.q = raw;
				filt_next.cnt = '0;
			end else begin
				filt_next.cnt = filt_reg.cnt + 10'h001;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			filt_reg <= '0;
		end else begin
			filt_reg <= filt_next;
		end
	end

	assign q = filt_reg.q;
endmodule

// >>> hdl/smw_timer.sv
`timescale 1ns/10ps
module smw_timer (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	smw_tick_if.snk                          tk,
	input  wire logic                        start,
	input  wire logic [smw_pkg::TCODE_W-1:0] code,
	output logic                             timeout
);
	import smw_pkg::*;

	typedef struct packed {
		logic              done;
		logic [TCNT_W-1:0] cnt;
	} smw_tmr_t;

	smw_tmr_t tmr_reg;
	smw_tmr_t tmr_next;

	always_comb begin
		tmr_next = tmr_reg;
		if (!start) begin
			tmr_next = '0;
		end else if (tk.ltick && !tmr_reg.done) begin
			tmr_next.cnt = tmr_reg.cnt + 19'h00001;
			if (tmr_next.cnt == smw_tmr_ticks(code)) begin
				tmr_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	assign timeout = tmr_reg.done;
endmodule

// >>> hdl/smw_supply_monitor.sv
`timescale 1ns/10ps
module smw_supply_monitor #(
	parameter int CAL_CYCLES_P = smw_pkg::CAL_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire smw_pkg::smw_chan_t            high_trip_detector,
	input  wire smw_pkg::smw_chan_t            low_trip_detector,
	input  wire smw_pkg::smw_chan_t            window_select,
	input  wire smw_pkg::smw_chan_t            filter_enable,
	output smw_pkg::smw_chan_t                 monitor_a,
	output smw_pkg::smw_chan_t                 monitor_b,
	output logic [2*smw_pkg::N_CHAN-1:0]       comp_status,
	output logic                               analog_ready,
	input  wire logic [smw_pkg::N_DIG-1:0]     dig_in,
	output logic [smw_pkg::N_DIG-1:0]          dig_sampled,
	input  wire logic                          internal_osc_select,
	input  wire logic                          clock_pin_drive_select,
	input  wire logic                          logic_clock_export_select,
	input  wire logic                          mclk_pin_in,
	output logic                               mclk_pin_out,
	output logic                               mclk_pin_oe_n,
	output logic                               logic_clock_out_pin,
	input  wire logic [smw_pkg::N_TMR-1:0]     timer_start,
	input  wire smw_pkg::smw_tcode_t           timer_code,
	output logic [smw_pkg::N_TMR-1:0]          timer_timeout,
	input  wire logic                          conv_req,
	input  wire logic [smw_pkg::CHAN_W-1:0]    conv_chan,
	input  wire logic                          conv_atten,
	output logic                               conv_busy,
	output logic                               conv_valid,
	output logic [smw_pkg::CHAN_W-1:0]         adc_mux_sel,
	output logic                               adc_start,
	input  wire logic                          adc_done,
	input  wire logic [smw_pkg::ADC_W-1:0]     adc_data,
	output logic [smw_pkg::RES_W-1:0]          adc_result,
	output logic [smw_pkg::RES_HI_W-1:0]       adc_result_hi,
	output logic [smw_pkg::RES_LO_W-1:0]       adc_result_lo
);
	import smw_pkg::*;

	typedef struct packed {
		// Clock pin synchroniser and edge history
		logic              pin_s1;
		logic              pin_s2;
		logic              pin_s3;
		// Internal oscillator divider and master clock pin drive
		logic [DIV_W-1:0]  osc_cnt;
		logic              mclk_lvl;
		logic              mclk_oe_n;
		logic              mtick;
		// Prescaler to logic clock
		logic [DIV_W-1:0]  pre_cnt;
		logic              ltick;
		logic              lclk_lvl;
		logic              lclk_pin;
		// Comparator synchronisers and resampled monitor outputs
		smw_chan_t         ca_s1;
		smw_chan_t         ca_s2;
		smw_chan_t         cb_s1;
		smw_chan_t         cb_s2;
		smw_chan_t         mon_a;
		smw_chan_t         mon_b;
		// General digital inputs
		logic [N_DIG-1:0]  dig_s1;
		logic [N_DIG-1:0]  dig_s2;
		logic [N_DIG-1:0]  dig_q;
		// Calibration
		logic [CAL_W-1:0]  cal_cnt;
		logic              ready;
		// Converter control
		smw_adc_st_t       adc_st;
		logic [CHAN_W-1:0] mux;
		logic              atten;
		logic              start;
		logic [RES_W-1:0]  res;
		logic              valid;
	} smw_top_t;

	smw_top_t  top_reg;
	smw_top_t  top_next;
	smw_chan_t win_a;
	smw_chan_t filt_a;
	smw_chan_t filt_b;
	logic      osc_tick;
	logic      ext_tick;

	smw_tick_if tk ();

	function automatic logic [RES_W-1:0] scale(input logic [ADC_W-1:0] d, input logic x3);
		logic [RES_W-1:0] w;
		w = {2'h0, d};
		// Times three as sum of value and value shifted by one
		return x3 ? RES_W'(w + {w[RES_W-2:0], 1'h0}) : w;
	endfunction

	// Comparator outputs arrive already high above trip, low below
	assign win_a = (window_select & top_reg.cb_s2 & ~top_reg.ca_s2)
		| (~window_select & top_reg.ca_s2);

	genvar gi;
	generate
		for (gi = 0; gi < N_CHAN; gi++) begin : g_chan
			smw_glitch_filter u_filt_a (
				.clk  (clk),
				.rstn (rstn),
				.tk   (tk),
				.raw  (win_a[gi]),
				.en   (filter_enable[gi]),
				.q    (filt_a[gi])
			);
			smw_glitch_filter u_filt_b (
				.clk  (clk),
				.rstn (rstn),
				.tk   (tk),
				.raw  (top_reg.cb_s2[gi]),
				.en   (filter_enable[gi]),
				.q    (filt_b[gi])
			);
		end
		for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
			smw_timer u_tmr (
				.clk     (clk),
				.rstn    (rstn),
				.tk      (tk),
				.start   (timer_start[gi]),
				.code    (timer_code[gi]),
				.timeout (timer_timeout[gi])
			);
		end
	endgenerate

	assign osc_tick = (top_reg.osc_cnt == DIV_W'(OSC_DIV - 1));
	assign ext_tick = top_reg.pin_s2 & ~top_reg.pin_s3;

	always_comb begin
		top_next = top_reg;

		// Master clock source
		top_next.pin_s1 = mclk_pin_in;
		top_next.pin_s2 = top_reg.pin_s1;
		top_next.pin_s3 = top_reg.pin_s2;
		top_next.osc_cnt = osc_tick ? '0 : top_reg.osc_cnt + 5'h01;
		top_next.mclk_lvl = (top_next.osc_cnt < DIV_W'(OSC_HALF));
		// Released unless internal oscillator and pin drive both selected
		top_next.mclk_oe_n = ~(internal_osc_select & clock_pin_drive_select);
		// Slave follows rising edges of the pin; a stopped pin stops the filters, timers, prescaler and input sampling
		top_next.mtick = internal_osc_select ? osc_tick : ext_tick;

		// Logic clock prescaler
		top_next.ltick = 1'b0;
		if (top_reg.mtick) begin
			top_next.pre_cnt = top_reg.pre_cnt + 5'h01;
			top_next.ltick = (top_reg.pre_cnt == DIV_W'(PRESCALE - 1));
			top_next.lclk_lvl = (top_next.pre_cnt < DIV_W'(PRESCALE / 2));
		end
		top_next.lclk_pin = logic_clock_export_select & top_next.lclk_lvl;

		// Asynchronous pin inputs pass two flip-flops first
		top_next.ca_s1 = high_trip_detector;
		top_next.ca_s2 = top_reg.ca_s1;
		top_next.cb_s1 = low_trip_detector;
		top_next.cb_s2 = top_reg.cb_s1;
		top_next.dig_s1 = dig_in;
		top_next.dig_s2 = top_reg.dig_s1;
		if (top_reg.mtick) begin
			top_next.dig_q = top_reg.dig_s2;
		end

		// Calibration window; filters track their inputs meanwhile
		if (!top_reg.ready) begin
			top_next.cal_cnt = top_reg.cal_cnt + 17'h00001;
			if (top_reg.cal_cnt == CAL_W'(CAL_CYCLES_P - 1)) begin
				top_next.ready = 1'b1;
			end
		end

		// Monitor outputs change only on logic clock ticks
		if (!top_reg.ready) begin
			top_next.mon_a = '0;
			top_next.mon_b = '0;
		end else if (top_reg.ltick) begin
			top_next.mon_a = filt_a;
			top_next.mon_b = filt_b;
		end

		// Converter control
		top_next.start = 1'b0;
		case (top_reg.adc_st)
			ADC_IDLE: begin
				// Requests before calibration ends are ignored
				if (conv_req && top_reg.ready) begin
					top_next.mux = conv_chan;
					top_next.atten = conv_atten;
					top_next.start = 1'b1;
					top_next.valid = 1'b0;
					top_next.adc_st = ADC_WAIT;
				end
			end
			ADC_WAIT: begin
				if (adc_done) begin
					top_next.res = scale(adc_data, top_reg.atten);
					top_next.valid = 1'b1;
					top_next.adc_st = ADC_IDLE;
				end
			end
			default: begin
				top_next.adc_st = ADC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			top_reg <= '0;
			top_reg.mclk_oe_n <= 1'b1;
			top_reg.adc_st <= ADC_IDLE;
		end else begin
			top_reg <= top_next;
		end
	end

	assign tk.mtick = top_reg.mtick;
	assign tk.ltick = top_reg.ltick;
	assign tk.init  = ~top_reg.ready;

	assign monitor_a = top_reg.mon_a;
	assign monitor_b = top_reg.mon_b;
	// One status word serves both the serial and the test-access readers
	assign comp_status = {top_reg.mon_b, top_reg.mon_a};
	assign analog_ready = top_reg.ready;
	assign dig_sampled = top_reg.dig_q;
	assign mclk_pin_out = top_reg.mclk_lvl;
	assign mclk_pin_oe_n = top_reg.mclk_oe_n;
	assign logic_clock_out_pin = top_reg.lclk_pin;
	assign conv_busy = (top_reg.adc_st != ADC_IDLE);
	assign conv_valid = top_reg.valid;
	assign adc_mux_sel = top_reg.mux;
	assign adc_start = top_reg.start;
	assign adc_result = top_reg.res;
	assign adc_result_hi = top_reg.res[RES_W-1:RES_LO_W];
	assign adc_result_lo = top_reg.res[RES_LO_W-1:0];
endmodule

// >>> testbench/smw_adc_model.sv
`timescale 1ns/10ps
module smw_adc_model
	import smw_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             adc_start,
	input  wire logic [3:0]       dly,
	input  wire logic [ADC_W-1:0] value,
	output logic                  adc_done,
	output logic [ADC_W-1:0]      adc_data
);
	int cnt;

	// Outside the done cycle the data bus shows the inverse, so a late sample cannot match
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			adc_done <= 1'b0;
			adc_data <= '0;
		end else begin
			adc_done <= 1'b0;
			adc_data <= ~value;
			if (adc_start)
				cnt <= int'(dly) + 1;
			else if (cnt == 1) begin
				adc_done <= 1'b1;
				adc_data <= value;
				cnt <= 0;
			end else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule

// >>> testbench/smw_assertions.sv
`timescale 1ns/10ps
module smw_checker
	import smw_pkg::*;
(
	input wire logic                clk,
	input wire logic                rstn,
	input wire logic                internal_osc_select,
	input wire logic                clock_pin_drive_select,
	input wire logic                logic_clock_export_select,
	input wire logic                mclk_pin_oe_n,
	input wire logic                logic_clock_out_pin,
	input wire logic                conv_req,
	input wire logic [CHAN_W-1:0]   conv_chan,
	input wire logic                conv_busy,
	input wire logic                conv_valid,
	input wire logic                analog_ready,
	input wire logic                adc_start,
	input wire logic [CHAN_W-1:0]   adc_mux_sel,
	input wire logic [RES_W-1:0]    adc_result,
	input wire logic [RES_HI_W-1:0] adc_result_hi,
	input wire logic [RES_LO_W-1:0] adc_result_lo,
	input wire smw_chan_t           monitor_a,
	input wire smw_chan_t           monitor_b,
	input wire logic [2*N_CHAN-1:0] comp_status,
	input wire logic [N_TMR-1:0]    timer_start,
	input wire logic [N_TMR-1:0]    timer_timeout
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_pin_driven: assert property (
		internal_osc_select && clock_pin_drive_select |=> !mclk_pin_oe_n)
		else $error("clock pin not driven in master mode");
	a_pin_released: assert property (
		!(internal_osc_select && clock_pin_drive_select) |=> mclk_pin_oe_n)
		else $error("clock pin driven outside master mode");
	a_export_off: assert property (
		!logic_clock_export_select |=> !logic_clock_out_pin)
		else $error("logic clock pin active while export is off");
	a_req_taken: assert property (
		conv_req && !conv_busy && analog_ready
		|=> adc_start && conv_busy && adc_mux_sel == $past(conv_chan))
		else $error("conversion request not taken");
	a_req_refused: assert property (
		conv_busy |=> !adc_start)
		else $error("converter started while busy");
	a_result_split: assert property (
		conv_valid |-> adc_result == {adc_result_hi, adc_result_lo})
		else $error("result halves disagree with result");
	a_valid_after_busy: assert property (
		$rose(conv_valid) |-> $past(conv_busy) && !conv_busy)
		else $error("result valid without a finished conversion");
	a_cal_quiet: assert property (
		!analog_ready |-> monitor_a == '0 && monitor_b == '0)
		else $error("monitor output active before ready");
	a_ready_holds: assert property (
		$rose(analog_ready) |=> analog_ready [*8])
		else $error("ready dropped");
	a_status_pair: assert property (
		comp_status == {monitor_b, monitor_a})
		else $error("status word differs from monitor outputs");
	a_timer_clear: assert property (
		1'b1 |=> (timer_timeout & ~$past(timer_start)) == '0)
		else $error("timeout held after start dropped");
endmodule

// >>> testbench/supply_monitor_window_clock_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end
module supply_monitor_window_clock_test;
	import smw_pkg::*;
	logic                clk, rstn, analog_ready, internal_osc_select, clock_pin_drive_select;
	logic                logic_clock_export_select, mclk_pin_in, mclk_pin_out, mclk_pin_oe_n;
	logic                logic_clock_out_pin, conv_req, conv_atten, conv_busy, conv_valid;
	logic                adc_start, adc_done, v_prev, slave_run;
	smw_chan_t           high_trip_detector, low_trip_detector, window_select, filter_enable;
	smw_chan_t           monitor_a, monitor_b, e_mon;
	logic [2*N_CHAN-1:0] comp_status;
	logic [N_DIG-1:0]    dig_in, dig_sampled;
	logic [N_TMR-1:0]    timer_start, timer_timeout;
	smw_tcode_t          timer_code;
	logic [CHAN_W-1:0]   conv_chan, adc_mux_sel;
	logic [ADC_W-1:0]    adc_data, m_value;
	logic [RES_W-1:0]    adc_result, e_res;
	logic [RES_HI_W-1:0] adc_result_hi;
	logic [RES_LO_W-1:0] adc_result_lo;
	logic [3:0]          m_dly;
	logic [31:0]         seed, r;
	logic [RES_W-1:0]    exp_q[$];
	int                  n_mismatch, n_checks, n, pcnt;

	// Short calibration keeps the run inside the cycle budget
	smw_supply_monitor #(.CAL_CYCLES_P(20)) smw_supply_monitor_inst (.*);
	smw_adc_model smw_adc_model_inst (.clk(clk), .rstn(rstn), .adc_start(adc_start),
		.dly(m_dly), .value(m_value), .adc_done(adc_done), .adc_data(adc_data));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wlev(input bit w, input bit v);
		while ((w ? logic_clock_out_pin : mclk_pin_out) !== v && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask

	// Rise-to-rise period in system clocks
	task automatic meas(input bit w);
		n = 0;
		wlev(w, 1'b0);
		wlev(w, 1'b1);
		n = 0;
		wlev(w, 1'b0);
		wlev(w, 1'b1);
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	// Another device's master clock on the shared pin: 40 clk period
	always @(posedge clk) begin
		if (slave_run) begin
			pcnt <= (pcnt == 39) ? 0 : pcnt + 1;
			mclk_pin_in <= (pcnt < 20);
		end
	end

	always @(negedge clk) begin
		if (conv_valid && !v_prev) begin
			e_res = exp_q.pop_front();
			`CHK(adc_result, e_res)
		end
		v_prev = conv_valid;
	end

	initial begin
		seed = 32'hc399;
		{rstn, v_prev, mclk_pin_in, conv_req, conv_atten, conv_chan, m_dly, m_value} = '0;
		{internal_osc_select, clock_pin_drive_select, logic_clock_export_select} = '0;
		{high_trip_detector, low_trip_detector, window_select, filter_enable} = '0;
		{timer_start, timer_code, dig_in} = '0;
		slave_run = 1'b0;
		pcnt = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (25) @(negedge clk);
		`CHK(analog_ready, 1'b1)
		r = rnd();
		@(posedge clk) dig_in <= r[3:0];
		repeat (40) @(negedge clk);
		`CHK(dig_sampled, dig_in)
		for (int m = 0; m < 4; m++) begin
			@(posedge clk) {internal_osc_select, clock_pin_drive_select} <= m[1:0];
			repeat (3) @(negedge clk);
			`CHK(mclk_pin_oe_n, m != 3)
		end
		@(posedge clk) logic_clock_export_select <= 1'b1;
		meas(1'b0);
		`CHK(n, 31)
		meas(1'b1);
		`CHK(n, 992)
		@(posedge clk) begin
			{internal_osc_select, clock_pin_drive_select} <= 2'b01;
			slave_run <= 1'b1;
		end
		meas(1'b1);
		`CHK(n, 1280)
		`CHK(mclk_pin_oe_n, 1'b1)
		@(posedge clk) begin
			{internal_osc_select, clock_pin_drive_select} <= 2'b11;
			slave_run <= 1'b0;
		end
		for (int c = 0; c < 2; c++) begin
			r = rnd();
			@(posedge clk) begin
				high_trip_detector <= r[9:0] & r[19:10];
				low_trip_detector <= r[19:10];
				window_select <= r[29:20];
			end
			repeat (5200) @(negedge clk);
			e_mon = (window_select & low_trip_detector & ~high_trip_detector)
				| (~window_select & high_trip_detector);
			`CHK(monitor_a, e_mon)
			`CHK(monitor_b, low_trip_detector)
		end
		@(posedge clk) begin
			filter_enable <= '1;
			high_trip_detector <= '0;
			low_trip_detector <= ~low_trip_detector;
		end
		repeat (6000) @(negedge clk);
		`CHK(monitor_b, ~low_trip_detector)
		repeat (11500) @(negedge clk);
		`CHK(monitor_b, low_trip_detector)
		@(posedge clk) begin
			timer_code <= {7'h33, 7'h7f, 7'h01, 7'h00};
			timer_start <= 4'b0011;
		end
		repeat (6900) @(negedge clk);
		`CHK(timer_timeout, 4'b0000)
		repeat (1050) @(negedge clk);
		`CHK(timer_timeout, 4'b0001)
		repeat (7940) @(negedge clk);
		`CHK(timer_timeout, 4'b0011)
		@(posedge clk) timer_start <= '0;
		repeat (2) @(negedge clk);
		`CHK(timer_timeout, 4'b0000)
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			exp_q.push_back(i[0] ? RES_W'(r[9:0]) * 12'h003 : RES_W'(r[9:0]));
			@(posedge clk) begin
				m_value <= r[9:0];
				m_dly <= r[13:10];
				conv_chan <= r[17:14] % 4'ha;
				conv_atten <= i[0];
				conv_req <= 1'b1;
			end
			// Held a second edge on purpose: the busy converter must ignore it
			@(posedge clk);
			@(posedge clk) conv_req <= 1'b0;
			n = 0;
			while (conv_busy !== 1'b0 && n < 100) begin
				@(negedge clk);
				n++;
			end
		end
		repeat (4) @(negedge clk);
		`CHK(exp_q.size(), 0)
		final_report();
	end
endmodule

bind smw_supply_monitor smw_checker smw_checker_inst (.*);
